// >>> fsir_host.sv
module fsir_host (
  input wire logic CLK,
  input wire logic WAITREQ,
  input wire logic [31:0] RDATA,
  output logic RD,
  output logic WR,
  output logic [fsir_pkg::FSIR_ADDR_W-1:0] ADDR,
  output logic [31:0] WDATA,
  output logic [3:0] BE
);
  timeunit 1ns;
  timeprecision 1ps;
  import fsir_pkg::*;
  initial begin
    RD = 1'b0;
    WR = 1'b0;
    ADDR = '0;
    WDATA = '0;
    BE = 4'hF;
  end
  // Request held until the edge that sees waitrequest low
  task automatic xfer(input logic w, input logic [15:0] idx,
                      input logic [15:0] d, input logic [3:0] b,
                      output logic [15:0] q);
    @(posedge CLK);
    RD <= !w;
    WR <= w;
    ADDR <= {idx, 2'h0};
    WDATA <= {16'h0000, d};
    BE <= b;
    do begin
      @(posedge CLK);
    end while (WAITREQ !== 1'b0);
    q = RDATA[15:0];
    RD <= 1'b0;
    WR <= 1'b0;
  endtask
endmodule // fsir_host

// >>> fsir_pkg.sv
package fsir_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int FSIR_ADDR_W = 18;
  localparam logic [15:0] FSIR_IDX_INT_STATUS = 16'hF241;
  localparam logic [15:0] FSIR_IDX_LOCK_START = 16'hF24C;
  localparam logic [15:0] FSIR_IDX_LOCK_END = 16'hF24D;
  localparam logic [15:0] FSIR_IDX_WP_STATE = 16'hF24E;
  localparam logic [15:0] FSIR_IDX_BLOCK_SEL = 16'hF300;
  localparam logic [15:0] FSIR_IDX_ECC_STATE = 16'hFF00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FSIR_BIT_INT = 15;
  localparam int FSIR_BIT_LOAD = 7;
  localparam int FSIR_BIT_PROG = 6;
  localparam int FSIR_BIT_ERASE = 5;
  localparam int FSIR_BIT_RESET = 4;
  localparam int FSIR_BLOCK_W = 9;
  localparam int FSIR_ECC_CODE_W = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] FSIR_INT_COLD_RST = 16'h8080;
  localparam logic [15:0] FSIR_LOCK_START_RST = 16'h0000;
  localparam logic [15:0] FSIR_BLOCK_SEL_RST = 16'h0000;
  localparam logic [15:0] FSIR_WP_STATE_RST = 16'h0002;
  localparam logic [15:0] FSIR_ECC_STATE_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] FSIR_ECC_NONE = 2'h0;
  localparam logic [1:0] FSIR_ECC_SINGLE = 2'h1;
  localparam logic [1:0] FSIR_ECC_DOUBLE = 2'h2;

  typedef enum logic [2:0] {
    FSIR_WP_UNLOCKED = 3'b100,
    FSIR_WP_LOCKED = 3'b010,
    FSIR_WP_TIGHT = 3'b001
  } fsir_wp_t;

  typedef enum logic [1:0] {
    FSIR_OP_LOCK = 2'b00,
    FSIR_OP_UNLOCK = 2'b01,
    FSIR_OP_TIGHT = 2'b10
  } fsir_lock_op_t;

  typedef enum logic [0:0] {
    FSIR_BUS_IDLE = 1'b0,
    FSIR_BUS_ACK = 1'b1
  } fsir_bus_state_t;

  // ----------------------------------------------------------------
  // Carriers from the operation engine
  // ----------------------------------------------------------------
  typedef struct packed {
    logic load_done;
    logic boot_done;
    logic program_done;
    logic erase_done;
    logic reset_cmd_done;
    logic warm_release;
    logic reset_busy;
    logic other_done;
  } fsir_events_t;

  typedef struct packed {
    logic update;
    logic spare;
    logic [1:0] sector;
    logic single_err;
    logic double_err;
  } fsir_ecc_t;

  typedef struct packed {
    logic valid;
    fsir_lock_op_t op;
  } fsir_lock_cmd_t;

endpackage

// >>> fsir_regs.sv
// Our own choice: the Avalon-MM register port.
module fsir_regs #(
  parameter int NUM_BLOCKS = 512
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [fsir_pkg::FSIR_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire fsir_pkg::fsir_events_t EVENTS,
  input wire fsir_pkg::fsir_ecc_t ECC_RESULT,
  input wire fsir_pkg::fsir_lock_cmd_t LOCK_CMD,
  output logic INT_FLAG,
  output logic [fsir_pkg::FSIR_BLOCK_W-1:0] LOCK_START_BLOCK,
  output logic [2:0] SEL_BLOCK_STATE
);
  import fsir_pkg::*;

  // Larger arrays would not be reachable through the nine-bit field
  if (NUM_BLOCKS < 2 ||
      NUM_BLOCKS > (1 << FSIR_BLOCK_W)) begin : g_block_check
    $error("NUM_BLOCKS out of range for the block field");
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic hits(input logic [FSIR_ADDR_W-1:0] addr,
                                input logic [15:0] idx);
    hits = (addr[FSIR_ADDR_W-1:2] == idx);
  endfunction

  // Double wins: a word with both flags set is not trusted as fixed
  function automatic logic [1:0] ecc_code(input logic single_err,
                                          input logic double_err);
    if (double_err) begin
      ecc_code = FSIR_ECC_DOUBLE;
    end else if (single_err) begin
      ecc_code = FSIR_ECC_SINGLE;
    end else begin
      ecc_code = FSIR_ECC_NONE;
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  fsir_bus_state_t bus_state;
  logic req;
  logic wr_take;
  logic [31:0] next_readdata;

  assign req = AVS_READ | AVS_WRITE;
  // Write lands on the edge where the master sees waitrequest low
  assign wr_take = AVS_WRITE & (bus_state == FSIR_BUS_ACK);

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      bus_state <= FSIR_BUS_IDLE;
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      case (bus_state)
        FSIR_BUS_IDLE: begin
          if (req) begin
            bus_state <= FSIR_BUS_ACK;
            AVS_WAITREQUEST <= 1'b0;
          end
        end
        FSIR_BUS_ACK: begin
          bus_state <= FSIR_BUS_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
        default: begin
          bus_state <= FSIR_BUS_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
      endcase
    end
  end

  logic wr_int;
  logic wr_start;
  logic wr_sel;
  assign wr_int = wr_take & hits(AVS_ADDRESS, FSIR_IDX_INT_STATUS);
  assign wr_start = wr_take & hits(AVS_ADDRESS, FSIR_IDX_LOCK_START);
  assign wr_sel = wr_take & hits(AVS_ADDRESS, FSIR_IDX_BLOCK_SEL);

  // ----------------------------------------------------------------
  // Completion flags
  // ----------------------------------------------------------------
  // Index 0 load, 1 program, 2 erase
  logic [2:0] op_flag;
  logic [2:0] op_set;
  logic [2:0] op_clr;
  logic [2:0] op_bit;
  logic reset_flag;
  logic reset_set;
  logic reset_clr;
  logic int_set;
  logic int_clr;

  assign op_set[0] = EVENTS.load_done | EVENTS.boot_done;
  assign op_set[1] = EVENTS.program_done;
  assign op_set[2] = EVENTS.erase_done;
  assign op_bit[0] = AVS_WRITEDATA[FSIR_BIT_LOAD];
  assign op_bit[1] = AVS_WRITEDATA[FSIR_BIT_PROG];
  assign op_bit[2] = AVS_WRITEDATA[FSIR_BIT_ERASE];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_op_flag
      // Zero written or reset ongoing; a writing one changes nothing
      assign op_clr[gi] = (wr_int & AVS_BYTEENABLE[0] & ~op_bit[gi])
                          | EVENTS.reset_busy;
      always_ff @(posedge CLK) begin
        if (!RSTN) begin
          op_flag[gi] <= FSIR_INT_COLD_RST[FSIR_BIT_LOAD - gi];
        end else if (op_set[gi]) begin
          op_flag[gi] <= 1'b1;
        end else if (op_clr[gi]) begin
          op_flag[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign reset_set = EVENTS.reset_cmd_done | EVENTS.warm_release;
  // Reset in progress deliberately absent from this clear term
  assign reset_clr = wr_int & AVS_BYTEENABLE[0]
                     & ~AVS_WRITEDATA[FSIR_BIT_RESET];

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      reset_flag <= FSIR_INT_COLD_RST[FSIR_BIT_RESET];
    end else if (reset_set) begin
      reset_flag <= 1'b1;
    end else if (reset_clr) begin
      reset_flag <= 1'b0;
    end
  end

  assign int_set = (|op_set) | reset_set | EVENTS.other_done;
  assign int_clr = (wr_int & AVS_BYTEENABLE[1]
                    & ~AVS_WRITEDATA[FSIR_BIT_INT]) | EVENTS.reset_busy;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      INT_FLAG <= FSIR_INT_COLD_RST[FSIR_BIT_INT];
    end else if (int_set) begin
      INT_FLAG <= 1'b1;
    end else if (int_clr) begin
      INT_FLAG <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Lock start block and block select
  // ----------------------------------------------------------------
  logic [FSIR_BLOCK_W-1:0] block_sel;
  logic [FSIR_BLOCK_W-1:0] next_start;
  logic [FSIR_BLOCK_W-1:0] next_sel;

  // Upper reserved bits are never stored
  always_comb begin
    next_start = LOCK_START_BLOCK;
    if (AVS_BYTEENABLE[0]) begin
      next_start[7:0] = AVS_WRITEDATA[7:0];
    end
    if (AVS_BYTEENABLE[1]) begin
      next_start[8] = AVS_WRITEDATA[8];
    end
  end

  always_comb begin
    next_sel = block_sel;
    if (AVS_BYTEENABLE[0]) begin
      next_sel[7:0] = AVS_WRITEDATA[7:0];
    end
    if (AVS_BYTEENABLE[1]) begin
      next_sel[8] = AVS_WRITEDATA[8];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      LOCK_START_BLOCK <= FSIR_LOCK_START_RST[FSIR_BLOCK_W-1:0];
    end else if (wr_start) begin
      LOCK_START_BLOCK <= next_start;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      block_sel <= FSIR_BLOCK_SEL_RST[FSIR_BLOCK_W-1:0];
    end else if (wr_sel) begin
      block_sel <= next_sel;
    end
  end

  // ----------------------------------------------------------------
  // Write protection state per block
  // ----------------------------------------------------------------
  fsir_wp_t wp_mem [NUM_BLOCKS];
  logic target_ok;
  logic sel_ok;

  // Lock commands act on the start block loaded beforehand
  assign target_ok = (32'(LOCK_START_BLOCK) < NUM_BLOCKS);
  assign sel_ok = (32'(block_sel) < NUM_BLOCKS);

  // Locked-tight blocks stay so until the next cold reset
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      for (int i = 0; i < NUM_BLOCKS; i++) begin
        wp_mem[i] <= FSIR_WP_LOCKED;
      end
    end else if (LOCK_CMD.valid && target_ok &&
                 wp_mem[LOCK_START_BLOCK] != FSIR_WP_TIGHT) begin
      case (LOCK_CMD.op)
        FSIR_OP_LOCK: begin
          wp_mem[LOCK_START_BLOCK] <= FSIR_WP_LOCKED;
        end
        FSIR_OP_UNLOCK: begin
          wp_mem[LOCK_START_BLOCK] <= FSIR_WP_UNLOCKED;
        end
        FSIR_OP_TIGHT: begin
          if (wp_mem[LOCK_START_BLOCK] == FSIR_WP_LOCKED) begin
            wp_mem[LOCK_START_BLOCK] <= FSIR_WP_TIGHT;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Reads follow the selected block
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      SEL_BLOCK_STATE <= FSIR_WP_STATE_RST[2:0];
    end else if (sel_ok) begin
      SEL_BLOCK_STATE <= wp_mem[block_sel];
    end else begin
      SEL_BLOCK_STATE <= FSIR_WP_LOCKED;
    end
  end

  // ----------------------------------------------------------------
  // Error correction status
  // ----------------------------------------------------------------
  // Bit pair 4k+1:4k spare k, 4k+3:4k+2 main k
  logic [15:0] ecc_state;
  logic [3:0] pair_pos;

  assign pair_pos = {ECC_RESULT.sector, ~ECC_RESULT.spare, 1'b0};

  generate
    for (gi = 0; gi < 8; gi++) begin : g_ecc_pair
      always_ff @(posedge CLK) begin
        if (!RSTN) begin
          ecc_state[2*gi +: 2] <= FSIR_ECC_STATE_RST[2*gi +: 2];
        end else if (ECC_RESULT.update &&
                     pair_pos == 4'(2 * gi)) begin
          // Main and spare land in their own pairs
          ecc_state[2*gi +: 2] <= ecc_code(ECC_RESULT.single_err,
                                         ECC_RESULT.double_err);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Registered one cycle after the request; the end block and unmapped
  // addresses read zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (hits(AVS_ADDRESS, FSIR_IDX_INT_STATUS)) begin
      next_readdata[FSIR_BIT_INT] = INT_FLAG;
      next_readdata[FSIR_BIT_LOAD] = op_flag[0];
      next_readdata[FSIR_BIT_PROG] = op_flag[1];
      next_readdata[FSIR_BIT_ERASE] = op_flag[2];
      next_readdata[FSIR_BIT_RESET] = reset_flag;
    end else if (hits(AVS_ADDRESS, FSIR_IDX_LOCK_START)) begin
      next_readdata[FSIR_BLOCK_W-1:0] = LOCK_START_BLOCK;
    end else if (hits(AVS_ADDRESS, FSIR_IDX_WP_STATE)) begin
      next_readdata[2:0] = SEL_BLOCK_STATE;
    end else if (hits(AVS_ADDRESS, FSIR_IDX_BLOCK_SEL)) begin
      next_readdata[FSIR_BLOCK_W-1:0] = block_sel;
    end else if (hits(AVS_ADDRESS, FSIR_IDX_ECC_STATE)) begin
      next_readdata[15:0] = ecc_state;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && bus_state == FSIR_BUS_IDLE) begin
      AVS_READDATA <= next_readdata;
    end
  end

endmodule // fsir_regs

// >>> fsir_regs_monitor.sv
module fsir_regs_monitor #(
  parameter int NUM_BLOCKS = 512
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [fsir_pkg::FSIR_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire fsir_pkg::fsir_events_t EVENTS,
  input wire fsir_pkg::fsir_ecc_t ECC_RESULT,
  input wire fsir_pkg::fsir_lock_cmd_t LOCK_CMD,
  input wire logic INT_FLAG,
  input wire logic [fsir_pkg::FSIR_BLOCK_W-1:0] LOCK_START_BLOCK,
  input wire logic [2:0] SEL_BLOCK_STATE
);
  import fsir_pkg::*;
  logic [15:0] idx;
  logic any_set;
  logic rd_ok;
  logic lsb_wr;
  assign idx = AVS_ADDRESS[17:2];
  assign any_set = (|EVENTS[7:2]) | EVENTS.other_done;
  assign rd_ok = AVS_READ && !AVS_WAITREQUEST;
  assign lsb_wr = AVS_WRITE && !AVS_WAITREQUEST && idx == FSIR_IDX_LOCK_START;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  a_set_raises_int: assert property (any_set |=> INT_FLAG)
    else $error("interrupt flag not set after a completion");
  a_busy_clears: assert property (
    EVENTS.reset_busy && !any_set |=> !INT_FLAG)
    else $error("interrupt flag survived reset in progress");
  a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  a_answer_soon: assert property (
    (AVS_READ || AVS_WRITE) |-> ##[0:2] !AVS_WAITREQUEST)
    else $error("bus request not answered in time");
  a_rd_upper_zero: assert property (
    rd_ok |-> AVS_READDATA[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_end_reads_zero: assert property (
    rd_ok && idx == FSIR_IDX_LOCK_END |-> AVS_READDATA == 32'h0)
    else $error("end block location not zero");
  a_lsb_rd_rsvd: assert property (
    rd_ok && idx == FSIR_IDX_LOCK_START |-> AVS_READDATA[15:9] == 7'h00)
    else $error("start block reserved bits set");
  a_wp_rd_onehot: assert property (
    rd_ok && idx == FSIR_IDX_WP_STATE |->
      $onehot(AVS_READDATA[15:0]) && AVS_READDATA[15:3] == 13'h0)
    else $error("protect state read not one-hot");
  a_sel_onehot: assert property ($onehot(SEL_BLOCK_STATE))
    else $error("selected block state not one-hot");
  a_lsb_write: assert property (
    lsb_wr && AVS_BYTEENABLE[1:0] == 2'h3 |=>
      LOCK_START_BLOCK == $past(AVS_WRITEDATA[8:0]))
    else $error("start block not written");
  a_lsb_hold: assert property (
    !lsb_wr |=> $stable(LOCK_START_BLOCK))
    else $error("start block changed without a write");

  c_load: cover property (EVENTS.load_done);
  c_busy: cover property (EVENTS.reset_busy);
  c_ecc: cover property (ECC_RESULT.update && ECC_RESULT.double_err);
  c_tight: cover property (LOCK_CMD.valid && LOCK_CMD.op == FSIR_OP_TIGHT);
endmodule // fsir_regs_monitor

bind fsir_regs fsir_regs_monitor #(.NUM_BLOCKS(NUM_BLOCKS)) u_mon (
  .CLK(CLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .EVENTS(EVENTS),
  .ECC_RESULT(ECC_RESULT), .LOCK_CMD(LOCK_CMD), .INT_FLAG(INT_FLAG),
  .LOCK_START_BLOCK(LOCK_START_BLOCK), .SEL_BLOCK_STATE(SEL_BLOCK_STATE));

// >>> tb_flash_status_interrupt_regs.sv
module tb_flash_status_interrupt_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import fsir_pkg::*;
  logic CLK, RSTN, rd, wr, wq, intf;
  logic [17:0] adr;
  logic [31:0] wd, rdat;
  logic [3:0] be;
  fsir_events_t ev;
  fsir_ecc_t ecc;
  fsir_lock_cmd_t lk;
  logic [8:0] lsb, blk;
  logic [2:0] sel;
  logic [15:0] q, e, eccx;
  logic [4:0] x;
  int err_total, n_compared, seed, k;
  fsir_lock_op_t ops[4] = '{FSIR_OP_UNLOCK, FSIR_OP_LOCK, FSIR_OP_TIGHT,
                            FSIR_OP_UNLOCK};
  logic [15:0] wpx[4] = '{16'h0004, 16'h0002, 16'h0001, 16'h0001};

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  fsir_host u_host (.CLK(CLK), .WAITREQ(wq), .RDATA(rdat), .RD(rd), .WR(wr),
    .ADDR(adr), .WDATA(wd), .BE(be));
  fsir_regs #(.NUM_BLOCKS(512)) u_dut (.CLK(CLK), .RSTN(RSTN),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq),
    .EVENTS(ev), .ECC_RESULT(ecc), .LOCK_CMD(lk), .INT_FLAG(intf),
    .LOCK_START_BLOCK(lsb), .SEL_BLOCK_STATE(sel));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] s,
                     input logic [15:0] w);
    n_compared++;
    if (s !== w) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, w, s);
    end
  endtask
  task automatic rdc(input string nm, input logic [15:0] idx,
                     input logic [15:0] w);
    u_host.xfer(1'b0, idx, 16'h0000, 4'hF, q);
    chk(nm, q, w);
  endtask
  task automatic wrt(input logic [15:0] idx, input logic [15:0] d,
                     input logic [3:0] b);
    u_host.xfer(1'b1, idx, d, b, q);
  endtask
  task automatic evp(input fsir_events_t v);
    @(posedge CLK);
    ev <= v;
    @(posedge CLK);
    ev <= '0;
  endtask
  function automatic logic [15:0] evx(int i);
    case (i)
      0, 1: return 16'h8080;
      2: return 16'h8040;
      3: return 16'h8020;
      default: return 16'h8010;
    endcase
  endfunction
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    wrap_up;
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 89713;
    RSTN = 1'b0;
    ev = '0;
    ecc = '0;
    lk = '0;
    eccx = '0;
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    rdc("int", FSIR_IDX_INT_STATUS, 16'h8080);
    rdc("start", FSIR_IDX_LOCK_START, 16'h0000);
    rdc("end", FSIR_IDX_LOCK_END, 16'h0000);
    rdc("wp", FSIR_IDX_WP_STATE, 16'h0002);
    rdc("ecc", FSIR_IDX_ECC_STATE, 16'h0000);
    rdc("unmapped", 16'h1234, 16'h0000);
    $display("test reset values ended");
    for (int i = 0; i < 6; i++) begin
      wrt(FSIR_IDX_INT_STATUS, 16'h0000, 4'hF);
      evp(fsir_events_t'(8'h80 >> i));
      rdc("flag", FSIR_IDX_INT_STATUS,
          evx(i));
      chk("int_pin", {15'h0000, intf}, 16'h0001);
    end
    evp(fsir_events_t'(8'hB8));
    evp(fsir_events_t'(8'h02));
    rdc("busy", FSIR_IDX_INT_STATUS, 16'h0010);
    chk("int_busy", {15'h0000, intf}, 16'h0000);
    evp(fsir_events_t'(8'h80));
    wrt(FSIR_IDX_INT_STATUS, 16'h0000, 4'h2);
    rdc("lane", FSIR_IDX_INT_STATUS, 16'h0090);
    wrt(FSIR_IDX_INT_STATUS, 16'hFFFF, 4'hF);
    rdc("ones", FSIR_IDX_INT_STATUS, 16'h0090);
    wrt(FSIR_IDX_INT_STATUS, 16'h0000, 4'hF);
    evp(fsir_events_t'(8'h01));
    rdc("other", FSIR_IDX_INT_STATUS, 16'h8000);
    $display("test completion flags ended");
    for (int i = 0; i < 4; i++) begin
      e = (i == 0) ? 16'hFFFF : 16'($random(seed));
      wrt(FSIR_IDX_LOCK_START, e, 4'hF);
      rdc("start", FSIR_IDX_LOCK_START, e & 16'h01FF);
      chk("start_pin", {7'h00, lsb}, e & 16'h01FF);
    end
    wrt(FSIR_IDX_ECC_STATE, 16'hFFFF, 4'hF);
    wrt(FSIR_IDX_WP_STATE, 16'hFFFF, 4'hF);
    wrt(FSIR_IDX_LOCK_END, 16'hFFFF, 4'hF);
    rdc("ecc_ro", FSIR_IDX_ECC_STATE, 16'h0000);
    rdc("wp_ro", FSIR_IDX_WP_STATE, 16'h0002);
    rdc("end_ro", FSIR_IDX_LOCK_END, 16'h0000);
    $display("test start block ended");
    blk = 9'($random(seed));
    wrt(FSIR_IDX_BLOCK_SEL, {7'h00, blk}, 4'hF);
    wrt(FSIR_IDX_LOCK_START, {7'h00, blk}, 4'hF);
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK);
      lk <= {1'b1, ops[i]};
      @(posedge CLK);
      lk <= '0;
      rdc("wp", FSIR_IDX_WP_STATE, wpx[i]);
      chk("sel_pin", {13'h0000, sel}, wpx[i]);
    end
    wrt(FSIR_IDX_BLOCK_SEL, {7'h00, blk ^ 9'h001}, 4'hF);
    rdc("wp_other", FSIR_IDX_WP_STATE, 16'h0002);
    $display("test protection ended");
    for (int i = 0; i < 12; i++) begin
      x = (i == 0) ? 5'h1F : 5'($random(seed));
      @(posedge CLK);
      ecc <= {1'b1, x};
      @(posedge CLK);
      ecc <= '0;
      // Spare code sits below its main code in each sector nibble
      k = x[3:2] * 4 + (x[4] ? 0 : 2);
      eccx[k +: 2] = x[0] ? FSIR_ECC_DOUBLE : {1'b0, x[1]};
      rdc("ecc", FSIR_IDX_ECC_STATE,
          eccx);
    end
    $display("test error codes ended");
    @(posedge CLK);
    RSTN <= 1'b0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    rdc("int_again", FSIR_IDX_INT_STATUS, 16'h8080);
    rdc("wp_again", FSIR_IDX_WP_STATE, 16'h0002);
    rdc("ecc_again", FSIR_IDX_ECC_STATE, 16'h0000);
    $display("test second reset ended");
    wrap_up;
  end
endmodule // tb_flash_status_interrupt_regs
